// file: sim/test_periodic_tick_counter.sv
`timescale 1ns/1ps
module test_periodic_tick_counter;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   tick_pkg::wb_req_t req = '0;
   tick_pkg::wb_rsp_t rsp;
   logic [2:0] srcv = 3'h0;
   logic dbg = 1'b0;
   logic dstop = 1'b0;
   logic irq;
   logic [31:0] q;
   logic [31:0] seed = 32'h1827;
   logic [7:0] lim;
   int n;
   int err_total = 0;
   int compares = 0;

   // Source bits: 2 low-power osc, 1 external, 0 internal
   periodic_tick_counter u_periodic_tick_counter (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
      .wb_rsp_o(rsp), .sources_i(tick_pkg::tick_sources_t'(srcv)), .debug_active_i(dbg),
      .deep_stop_i(dstop), .tick_irq_o(irq));

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   function automatic logic [31:0] exp_cnt(input int e, input int l);
      return 32'(e % (l + 1));
   endfunction : exp_cnt

   function automatic logic [31:0] exp_flag(input int e, input int l);
      return (e > l) ? 32'h00000080 : 32'h00000000;
   endfunction : exp_flag

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Holds the request until ack is sampled; data taken at that edge
   task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] d);
      int w;
      w = 0;
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h000000, d}};
      do begin
         @(posedge clk_i);
         w++;
      end while (rsp.ack !== 1'b1 && w < 50);
      q = rsp.dat;
      req <= '0;
      if (w >= 50) chk("ack", 32'h00000001, 32'h00000000);
   endtask : bus

   task automatic rdchk(input string what, input logic [3:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 8'h00);
      chk(what, exp, q);
   endtask : rdchk

   // Two cycles high, two low per edge, then settle
   task automatic pulse(input logic [2:0] m, input int k);
      repeat (k) begin
         @(posedge clk_i);
         srcv <= m;
         repeat (2) @(posedge clk_i);
         srcv <= 3'h0;
         @(posedge clk_i);
      end
      repeat (3) @(posedge clk_i);
   endtask : pulse

   task automatic irqchk(input logic exp);
      @(posedge clk_i);
      chk("irq", {31'h00000000, exp}, {31'h00000000, irq});
   endtask : irqchk

   task final_report;
      if (err_total == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report

   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      final_report();
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk("status", 4'h0, 32'h00000000);
      rdchk("count", 4'h4, 32'h00000000);
      rdchk("limit", 4'h8, 32'h00000000);
      pulse(3'h4, 3);
      rdchk("count", 4'h4, 32'h00000000);
      lim = 8'(2 + xs() % 5);
      n = int'(xs() % 20);
      bus(1'b1, 4'h8, lim);
      rdchk("limit", 4'h8, {24'h000000, lim});
      bus(1'b1, 4'h0, 8'h08);
      pulse(3'h4, n);
      rdchk("count", 4'h4, exp_cnt(n, lim));
      rdchk("status", 4'h0, exp_flag(n, lim) | 32'h00000008);
      pulse(3'h4, lim + 1);
      rdchk("status", 4'h0, 32'h00000088);
      irqchk(1'b0);
      bus(1'b1, 4'h0, 8'h18);
      irqchk(1'b1);
      rdchk("status", 4'h0, 32'h00000098);
      bus(1'b1, 4'h0, 8'h98);
      irqchk(1'b0);
      bus(1'b1, 4'h0, 8'h19);
      rdchk("count", 4'h4, 32'h00000000);
      pulse(3'h4, 4);
      rdchk("count", 4'h4, 32'h00000002);
      bus(1'b1, 4'h0, 8'h59);
      rdchk("count", 4'h4, 32'h00000000);
      pulse(3'h1, 2);
      pulse(3'h4, 2);
      rdchk("count", 4'h4, 32'h00000001);
      dbg <= 1'b1;
      pulse(3'h1, 4);
      dbg <= 1'b0;
      pulse(3'h1, 2);
      rdchk("count", 4'h4, 32'h00000002);
      bus(1'b1, 4'h8, 8'h00);
      rdchk("count", 4'h4, 32'h00000000);
      bus(1'b1, 4'h0, 8'hD8);
      pulse(3'h1, 1);
      rdchk("status", 4'h0, 32'h000000D8);
      irqchk(1'b1);
      bus(1'b1, 4'h4, 8'h55);
      rdchk("count", 4'h4, 32'h00000000);
      rdchk("unmapped", 4'hC, 32'h00000000);
      bus(1'b1, 4'h8, 8'hFF);
      dstop <= 1'b1;
      pulse(3'h1, 3);
      rdchk("count", 4'h4, 32'h00000000);
      bus(1'b1, 4'h0, 8'h88);
      pulse(3'h4, 3);
      rdchk("count", 4'h4, 32'h00000003);
      dstop <= 1'b0;
      bus(1'b1, 4'h0, 8'h00);
      pulse(3'h4, 3);
      rdchk("count", 4'h4, 32'h00000000);
      bus(1'b1, 4'h0, 8'h28);
      pulse(3'h2, 1000);
      rdchk("count", 4'h4, 32'h00000001);
      final_report();
   end
endmodule : test_periodic_tick_counter

// file: verilog/periodic_tick_counter.sv
`timescale 1ns/1ps
// Operation
// - Eight-bit up-counter fed by prescaler, compared against eight-bit limit.
// - Count up each tick until equal to limit, then wrap to zero.
// - Match flag sets on the wrap from limit to zero.
// - Limit zero sets the match flag on every prescaler tick.
// - Writing one to flag clears flag and request; zero leaves it.
// - Interrupt request is flag and enable both set.
// - Reset: counter, limit, divider, flag, enable, source all cleared.
// - Source 00 low-power oscillator, 01 external reference, 1x internal reference.
// - Changing the source select clears prescaler and counter.
// - Changing the divider select clears prescaler and counter.
// - Divider code zero stops the prescaler; nonzero starts it.
// - Source low bit 0: binary and decimal divide table, low set.
// - Source low bit 1: binary and decimal divide table, high set.
// - Any limit write clears prescaler and counter.
// - Count register reads live count and ignores writes.
// - Debug halt suspends counting; resumes from held value afterwards.
// - In deep stop only the low-power oscillator may drive counting.
module periodic_tick_counter (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire tick_pkg::wb_req_t wb_req_i,
   output tick_pkg::wb_rsp_t wb_rsp_o,
   input wire tick_pkg::tick_sources_t sources_i,
   input wire logic debug_active_i,
   input wire logic deep_stop_i,
   output logic tick_irq_o
);
   logic [tick_pkg::CNT_W-1:0] count;
   logic [tick_pkg::CNT_W-1:0] limit;
   logic [tick_pkg::PRE_W-1:0] pre_count;
   logic [1:0] source_sel;
   logic [3:0] divider_sel;
   logic match_flag;
   logic irq_en;
   logic src_prev;
   logic ack;
   logic [31:0] rd_data;

   logic [tick_pkg::CNT_W-1:0] next_count;
   logic [tick_pkg::CNT_W-1:0] next_limit;
   logic [tick_pkg::PRE_W-1:0] next_pre_count;
   logic [1:0] next_source_sel;
   logic [3:0] next_divider_sel;
   logic next_match_flag;
   logic next_irq_en;
   logic next_ack;
   logic [31:0] next_rd_data;

   logic src_level;
   logic src_edge;
   logic pre_tick;
   logic bus_access;
   logic wr_lane;
   logic wr_status;
   logic wr_limit;
   logic clear_counters;
   logic [tick_pkg::PRE_W-1:0] div_value;

   // Divide ratio; zero means prescaler off
   function automatic logic [tick_pkg::PRE_W-1:0] divide_ratio(input logic high_set,
                                                               input logic [3:0] code);
      logic [tick_pkg::PRE_W-1:0] r;
      r = tick_pkg::PRE_ZERO;
      if (!high_set) begin
         unique case (code)
            4'h0: r = 18'h00000;
            4'h1: r = 18'h00008;
            4'h2: r = 18'h00020;
            4'h3: r = 18'h00040;
            4'h4: r = 18'h00080;
            4'h5: r = 18'h00100;
            4'h6: r = 18'h00200;
            4'h7: r = 18'h00400;
            4'h8: r = 18'h00001;
            4'h9: r = 18'h00002;
            4'hA: r = 18'h00004;
            4'hB: r = 18'h0000A;
            4'hC: r = 18'h00010;
            4'hD: r = 18'h00064;
            4'hE: r = 18'h001F4;
            4'hF: r = 18'h003E8;
         endcase
      end else begin
         unique case (code)
            4'h0: r = 18'h00000;
            4'h1: r = 18'h00400;
            4'h2: r = 18'h00800;
            4'h3: r = 18'h01000;
            4'h4: r = 18'h02000;
            4'h5: r = 18'h04000;
            4'h6: r = 18'h08000;
            4'h7: r = 18'h10000;
            4'h8: r = 18'h003E8;
            4'h9: r = 18'h007D0;
            4'hA: r = 18'h01388;
            4'hB: r = 18'h02710;
            4'hC: r = 18'h04E20;
            4'hD: r = 18'h0C350;
            4'hE: r = 18'h186A0;
            4'hF: r = 18'h30D40;
         endcase
      end
      return r;
   endfunction : divide_ratio

   // Source clocks arrive as levels synchronous to clk_i, so an edge
   // detector is enough; a true async source would need a synchroniser here
   always_comb begin
      if (source_sel[1]) begin
         src_level = sources_i.internal_ref_clock;
      end else if (source_sel == tick_pkg::SRC_EXT) begin
         src_level = sources_i.external_ref_clock;
      end else begin
         src_level = sources_i.low_power_osc_clock;
      end
   end

   assign div_value = divide_ratio(source_sel[0], divider_sel);
   // edges counted in the bus domain
   assign src_edge = src_level && !src_prev && !debug_active_i
                     && !(deep_stop_i && source_sel != tick_pkg::SRC_LPO)
                     && divider_sel != tick_pkg::DIV_OFF;
   // Ratio minus one: the tick lands on the edge that completes the ratio
   assign pre_tick = src_edge && (pre_count == div_value - 18'h00001);

   assign bus_access = wb_req_i.cyc && wb_req_i.stb;
   // Writes land on the ack edge, the one at which the master samples the answer
   assign wr_lane = bus_access && ack && wb_req_i.we && wb_req_i.sel[0];
   assign wr_status = wr_lane && wb_req_i.adr == tick_pkg::STATUS_CONTROL_OFS;
   assign wr_limit = wr_lane && wb_req_i.adr == tick_pkg::MATCH_LIMIT_OFS;
   // A clearing write outranks a tick in the same cycle
   assign clear_counters = wr_limit
      || (wr_status && wb_req_i.dat[tick_pkg::SRC_HI:tick_pkg::SRC_LO] != source_sel)
      || (wr_status && wb_req_i.dat[tick_pkg::DIV_HI:0] != divider_sel);

   always_comb begin
      next_count = count;
      next_pre_count = pre_count;
      next_limit = limit;
      next_source_sel = source_sel;
      next_divider_sel = divider_sel;
      next_irq_en = irq_en;
      next_match_flag = match_flag;
      // Cleared first so a wrap in the same cycle still sets it
      if (wr_status && wb_req_i.dat[tick_pkg::FLAG_BIT]) begin
         next_match_flag = 1'b0;
      end
      if (clear_counters) begin
         next_count = tick_pkg::CNT_RESET;
         next_pre_count = tick_pkg::PRE_ZERO;
      end else if (src_edge) begin
         if (pre_tick) begin
            next_pre_count = tick_pkg::PRE_ZERO;
            if (count == limit) begin
               next_count = tick_pkg::CNT_RESET;
               next_match_flag = 1'b1;
            end else begin
               next_count = count + 8'h01;
            end
         end else begin
            next_pre_count = pre_count + 18'h00001;
         end
      end
      if (wr_status) begin
         next_source_sel = wb_req_i.dat[tick_pkg::SRC_HI:tick_pkg::SRC_LO];
         next_divider_sel = wb_req_i.dat[tick_pkg::DIV_HI:0];
         next_irq_en = wb_req_i.dat[tick_pkg::IRQ_EN_BIT];
      end
      if (wr_limit) begin
         next_limit = wb_req_i.dat[tick_pkg::CNT_W-1:0];
      end
   end

   always_comb begin
      next_ack = bus_access && !ack;
      next_rd_data = rd_data;
      // Captured when the request is first seen; the count may move before ack
      if (bus_access && !ack) begin
         unique case (wb_req_i.adr)
            tick_pkg::STATUS_CONTROL_OFS:
               next_rd_data = {24'h000000, match_flag, source_sel, irq_en, divider_sel};
            tick_pkg::COUNT_VALUE_OFS: next_rd_data = {24'h000000, count};
            tick_pkg::MATCH_LIMIT_OFS: next_rd_data = {24'h000000, limit};
            default: next_rd_data = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= tick_pkg::CNT_RESET;
         limit <= tick_pkg::LIMIT_RESET;
         pre_count <= tick_pkg::PRE_ZERO;
         source_sel <= tick_pkg::SRC_LPO;
         divider_sel <= tick_pkg::DIV_OFF;
         match_flag <= 1'b0;
         irq_en <= 1'b0;
         src_prev <= 1'b0;
         ack <= 1'b0;
         rd_data <= 32'h00000000;
      end else begin
         count <= next_count;
         limit <= next_limit;
         pre_count <= next_pre_count;
         source_sel <= next_source_sel;
         divider_sel <= next_divider_sel;
         match_flag <= next_match_flag;
         irq_en <= next_irq_en;
         src_prev <= src_level;
         ack <= next_ack;
         rd_data <= next_rd_data;
      end
   end

   assign tick_irq_o = match_flag && irq_en;
   assign wb_rsp_o = '{ack: ack, dat: rd_data};

   // Checks watch registered state on the same edge as the logic
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Reset is the one place where the default disable must not apply
   reset_state_a: assert property (disable iff (1'b0) rst_i |=> count == tick_pkg::CNT_RESET
      && limit == tick_pkg::LIMIT_RESET && pre_count == tick_pkg::PRE_ZERO && !match_flag && !irq_en
      && source_sel == tick_pkg::SRC_LPO && divider_sel == tick_pkg::DIV_OFF && !tick_irq_o)
      else $error("reset left state behind");

   ack_answer_a: assert property (bus_access && !ack |=> ack ##1 !ack)
      else $error("ack not a single-cycle answer");

   irq_follows_flag_a: assert property ($rose(match_flag) && $past(irq_en) && !$past(wr_status)
      |-> tick_irq_o)
      else $error("irq not raised on flag with enable");

   wrap_sets_flag_a: assert property (pre_tick && count == limit && !clear_counters
      |=> count == tick_pkg::CNT_RESET && match_flag)
      else $error("wrap did not clear count and set flag");

   limit_zero_flag_a: assert property (limit == 8'h00 && pre_tick && !clear_counters
      |=> match_flag && count == tick_pkg::CNT_RESET)
      else $error("zero limit did not flag on a tick");

   count_step_a: assert property (pre_tick && count != limit && !clear_counters
      |=> count == $past(count) + 8'h01)
      else $error("count did not step by one");

   flag_clear_a: assert property (wr_status && wb_req_i.dat[tick_pkg::FLAG_BIT]
      && !(pre_tick && count == limit) |=> !match_flag && !tick_irq_o)
      else $error("flag write one did not clear");

   flag_sticky_a: assert property (match_flag && !(wr_status && wb_req_i.dat[tick_pkg::FLAG_BIT])
      |=> match_flag)
      else $error("flag dropped without a write one");

   limit_write_clears_a: assert property (wr_limit |=> count == tick_pkg::CNT_RESET && pre_count == tick_pkg::PRE_ZERO)
      else $error("limit write did not clear counters");

   source_change_a: assert property (wr_status && wb_req_i.dat[tick_pkg::SRC_HI:tick_pkg::SRC_LO] != source_sel
      |=> count == tick_pkg::CNT_RESET && pre_count == tick_pkg::PRE_ZERO)
      else $error("source change did not clear counters");

   divider_change_a: assert property (wr_status && wb_req_i.dat[tick_pkg::DIV_HI:0] != divider_sel
      |=> count == tick_pkg::CNT_RESET && pre_count == tick_pkg::PRE_ZERO)
      else $error("divider change did not clear counters");

   divider_off_a: assert property (divider_sel == tick_pkg::DIV_OFF && !clear_counters
      |-> !pre_tick ##1 count == $past(count) && pre_count == $past(pre_count))
      else $error("count moved with prescaler off");

   // Prescaler must never sit at or past its ratio, or ticks would be lost
   prescaler_bound_a: assert property (divider_sel != tick_pkg::DIV_OFF |-> pre_count < div_value)
      else $error("prescaler beyond its ratio");

   pre_step_a: assert property (src_edge && !pre_tick && !clear_counters
      |=> pre_count == $past(pre_count) + 18'h00001 && count == $past(count))
      else $error("prescaler did not step on a source edge");

   divide_by_one_a: assert property (src_edge && !clear_counters && !source_sel[0]
      && divider_sel == 4'h8 |-> pre_tick)
      else $error("divide by one missed a tick");

   count_write_ignored_a: assert property (wr_lane && wb_req_i.adr == tick_pkg::COUNT_VALUE_OFS
      && !pre_tick |=> count == $past(count))
      else $error("count register took a write");

   read_count_a: assert property (bus_access && !ack && wb_req_i.adr == tick_pkg::COUNT_VALUE_OFS
      |=> wb_rsp_o.dat == {24'h000000, $past(count)})
      else $error("count read did not return the live count");

   // Edge detector keeps tracking in a halt, so no stale edge fires on resume
   debug_hold_a: assert property (debug_active_i && !wr_lane
      |=> count == $past(count) && pre_count == $past(pre_count))
      else $error("counting moved during debug halt");

   deep_stop_gate_a: assert property (deep_stop_i && source_sel != tick_pkg::SRC_LPO && !clear_counters
      |=> count == $past(count) && pre_count == $past(pre_count))
      else $error("reference clock counted in deep stop");
endmodule : periodic_tick_counter

// file: verilog/tick_pkg.sv
package tick_pkg;
   localparam int ADR_W = 4;
   localparam int CNT_W = 8;
   localparam int PRE_W = 18;
   localparam logic [ADR_W-1:0] STATUS_CONTROL_OFS = 4'h0;
   localparam logic [ADR_W-1:0] COUNT_VALUE_OFS = 4'h4;
   localparam logic [ADR_W-1:0] MATCH_LIMIT_OFS = 4'h8;
   localparam int FLAG_BIT = 7;
   localparam int SRC_HI = 6;
   localparam int SRC_LO = 5;
   localparam int IRQ_EN_BIT = 4;
   localparam int DIV_HI = 3;
   localparam logic [1:0] SRC_LPO = 2'h0;
   localparam logic [1:0] SRC_EXT = 2'h1;
   localparam logic [3:0] DIV_OFF = 4'h0;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
   localparam logic [CNT_W-1:0] LIMIT_RESET = 8'h00;
   localparam logic [PRE_W-1:0] PRE_ZERO = 18'h00000;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;

   typedef struct packed {
      logic low_power_osc_clock;
      logic external_ref_clock;
      logic internal_ref_clock;
   } tick_sources_t;
endpackage : tick_pkg
